// >>> itx_map.svh
// Offsets, field values, codes and the limit reset value of the
// isochronous transmit sequencer. Included by the package.
`ifndef ITX_MAP_SVH
`define ITX_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses) and limit reset value
// ----------------------------------------
`define ITX_REG_CTRL 8'h00
`define ITX_REG_PTR 8'h04
`define ITX_REG_EVT 8'h08
`define ITX_REG_LIM 8'h0c
`define ITX_LIM_RST 8'h08

// ----------------------------------------
// Event codes
// ----------------------------------------
`define ITX_EVT_UNDERRUN 5'h04
`define ITX_EVT_DESC_READ 5'h06
`define ITX_EVT_DATA_READ 5'h07
`define ITX_EVT_DATA_WRITE 5'h08
`define ITX_EVT_TCODE 5'h0b
`define ITX_EVT_UNKNOWN 5'h0e
`define ITX_EVT_COMPLETE 5'h11

// ----------------------------------------
// Descriptor fields
// ----------------------------------------
`define ITX_CMD_MORE 4'h0
`define ITX_CMD_LAST 4'h1
`define ITX_CMD_STORE 4'h8
`define ITX_KEY_IMM 3'h2
`define ITX_TCODE_ISO 4'ha
`define ITX_INT_ALWAYS 2'h3
`define ITX_INT_DONE 2'h1
`define ITX_SPD_100 3'h0
`define ITX_SPD_200 3'h1
`define ITX_SPD_400 3'h2
`endif

// >>> itx_pkg.sv
// Types of the isochronous transmit sequencer.
// Assumes itx_map.svh is on the include path.
`include "itx_map.svh"
package itx_pkg;
  typedef enum logic [3:0] {
    ITX_IDLE = 4'b0000, ITX_FETCH = 4'b0001, ITX_DECODE = 4'b0010,
    ITX_STORE = 4'b0011, ITX_HEADER = 4'b0100, ITX_PAYLOAD = 4'b0101,
    ITX_WAIT_TX = 4'b0110, ITX_INTR = 4'b0111, ITX_STATUS = 4'b1000,
    ITX_SKIP = 4'b1001
  } itx_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } itx_dma_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } itx_dma_rsp_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } itx_queue_t;

  // Serial bus layout of the stream header
  typedef struct packed {
    logic [2:0] spd;
    logic [15:0] len;
    logic [1:0] tag;
    logic [5:0] chan;
    logic [3:0] tcode;
    logic [3:0] sy;
  } itx_hdr_t;

  typedef struct packed {
    itx_state_t state;
    logic go;
    logic newprog;
    logic in_pay;
    logic abn;
    logic done;
    logic fatal;
    logic flush;
    logic hdr_v;
    logic [4:0] evt;
    logic [2:0] idx;
    logic [7:0] skips;
    logic [7:0] lim;
    logic [15:0] cnt;
    logic [31:0] pp;
    logic [31:0] da;
    logic [31:0] skip;
    logic [31:0] baddr;
    logic [7:0][31:0] ram;
    itx_dma_req_t dma;
    itx_queue_t q;
    itx_hdr_t hdr;
    logic wb_ack;
    logic [31:0] wb_dat;
  } itx_st_t;
endpackage : itx_pkg

// >>> itx_sequencer.sv
// Isochronous transmit context sequencer with Wishbone registers.
// Assumes a single-word DMA master port to host memory and a
// link transmitter that drains the queue and reports done/underrun.
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "itx_map.svh"

// Function
// - Store value writes zero-extended half to buffer
// - Immediate header copied from work RAM
// - Header final interrupts, continue fetches payload
// - Payload moved; continue repeats, final interrupts
// - Descriptor fetch bus error reports 06h
// - Unprocessable program or long loss reports 0Eh
// - Payload read bus error reports 07h
// - Status or store write error reports 08h
// - Tcode not Ah reports 0Bh, no send
// - Queue underrun during send reports 04h
// - Completed packet reports 11h
// - Event field written; status written when flagged
// - Abnormal: flush, fatal flag when select 11b, pointer, idle
// - Normal: done flag when select 11b/01b
// - Block count zero idles, else branch
// - Bus reset or lost cycle takes skip
// - Transmit error discards packet, takes skip
// - Speed code 000b/001b/010b in header; the code copies any 3-bit value from bits 18:16 unchecked
// - Header tag, channel, tcode, sy, length
// - Header converted to serial bus layout
module itx_sequencer import itx_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output itx_dma_req_t dma_o,
  input wire itx_dma_rsp_t dma_i,
  output itx_queue_t tq_o,
  input wire logic tq_ready,
  output logic tq_flush,
  output itx_hdr_t link_hdr,
  output logic link_hdr_valid,
  input wire logic link_done,
  input wire logic link_underrun,
  input wire logic bus_reset,
  input wire logic cycle_lost,
  input wire logic [15:0] cycle_timer,
  output logic ctx_active
);
  itx_st_t s;
  itx_st_t n;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [15:0] dec4(input logic [15:0] c);
    return (c > 16'h0004) ? 16'(c - 16'h0004) : 16'h0000;
  endfunction : dec4

  // Completion of a program, normal or not
  function automatic itx_st_t finish(input itx_st_t st);
    itx_st_t r;
    logic [1:0] isel;
    r = st;
    isel = st.ram[0][21:20];
    if (st.abn) begin
      r.flush = 1'b1;
      r.q.valid = 1'b0;
      if (isel == `ITX_INT_ALWAYS) begin
        r.fatal = 1'b1;
      end
      r.pp = st.da;
      r.state = ITX_IDLE;
    end else begin
      if (isel == `ITX_INT_ALWAYS || isel == `ITX_INT_DONE) begin
        r.done = 1'b1;
      end
      if (st.ram[2][3:0] == 4'h0) begin
        r.state = ITX_IDLE;
      end else begin
        r.pp = {st.ram[2][31:4], 4'h0};
        r.da = {st.ram[2][31:4], 4'h0};
        r.newprog = 1'b1;
        r.idx = 3'h0;
        r.skips = 8'h00;
        r.state = ITX_FETCH;
      end
    end
    return r;
  endfunction : finish

  logic [3:0] cmd;
  logic imm;
  logic bus_go;
  logic q_free;
  assign cmd = s.ram[0][31:28];
  assign imm = (s.ram[0][26:24] == `ITX_KEY_IMM);
  assign bus_go = wb_cyc_i & wb_stb_i;
  assign q_free = ~s.q.valid | tq_ready;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = s;
    n.flush = 1'b0;
    n.hdr_v = 1'b0;
    if (s.q.valid && tq_ready) begin
      n.q.valid = 1'b0;
    end
    // Ack one cycle after the strobe, dropped the cycle after
    n.wb_ack = bus_go & ~s.wb_ack;
    if (bus_go && !s.wb_ack) begin
      if (wb_adr_i == `ITX_REG_CTRL) begin
        n.wb_dat = {19'h0, s.evt, 6'h0, (s.state != ITX_IDLE), s.go};
      end else if (wb_adr_i == `ITX_REG_PTR) begin
        n.wb_dat = s.pp;
      end else if (wb_adr_i == `ITX_REG_EVT) begin
        n.wb_dat = {30'h0, s.fatal, s.done};
      end else if (wb_adr_i == `ITX_REG_LIM) begin
        n.wb_dat = {24'h0, s.lim};
      end else begin
        n.wb_dat = 32'h0;
      end
    end
    // Writes land on the edge that sees ack high
    if (bus_go && s.wb_ack && wb_we_i) begin
      if (wb_adr_i == `ITX_REG_CTRL) begin
        if (wb_sel_i[0] && wb_dat_i[0]) begin
          n.go = 1'b1;
        end
      end else if (wb_adr_i == `ITX_REG_PTR) begin
        if (s.state == ITX_IDLE) begin
          n.pp = merge(s.pp, wb_dat_i, wb_sel_i);
        end
      end else if (wb_adr_i == `ITX_REG_EVT) begin
        if (wb_sel_i[0]) begin
          n.done = s.done & ~wb_dat_i[0];
          n.fatal = s.fatal & ~wb_dat_i[1];
        end
      end else if (wb_adr_i == `ITX_REG_LIM) begin
        if (wb_sel_i[0]) begin
          n.lim = wb_dat_i[7:0];
        end
      end
    end

    // FSM runs after the bus, so an event flag set beats a clear
    case (s.state)
      ITX_IDLE: begin
        if (s.go) begin
          n.go = 1'b0;
          n.da = s.pp;
          n.newprog = 1'b1;
          n.in_pay = 1'b0;
          n.abn = 1'b0;
          n.skips = 8'h00;
          n.idx = 3'h0;
          n.state = ITX_FETCH;
        end
      end
      ITX_FETCH: begin
        if (!s.dma.req) begin
          n.dma = '{1'b1, 1'b0, 32'(s.da + {27'h0, s.idx, 2'b00}), 32'h0};
        end else if (dma_i.ack) begin
          n.dma.req = 1'b0;
          if (dma_i.err) begin
            n.evt = `ITX_EVT_DESC_READ;
            n.abn = 1'b1;
            n.state = ITX_INTR;
          end else begin
            n.ram[s.idx] = dma_i.rdata;
            n.idx = 3'(s.idx + 3'h1);
            // Immediate descriptors carry four header words more
            if (s.idx == 3'h7 || (s.idx == 3'h3 && !imm)) begin
              n.state = ITX_DECODE;
            end
          end
        end
      end
      ITX_DECODE: begin
        n.newprog = 1'b0;
        if (s.newprog) begin
          n.skip = s.ram[2];
        end
        if (s.newprog && (bus_reset || cycle_lost)) begin
          n.skip = s.ram[2];
          n.state = ITX_SKIP;
        end else if (cmd == `ITX_CMD_STORE && !s.in_pay) begin
          n.state = ITX_STORE;
        end else if (imm && !s.in_pay &&
                     (cmd == `ITX_CMD_MORE || cmd == `ITX_CMD_LAST)) begin
          if (s.ram[4][7:4] != `ITX_TCODE_ISO) begin
            n.evt = `ITX_EVT_TCODE;
            n.state = ITX_SKIP;
          end else begin
            n.cnt = s.ram[0][15:0];
            n.idx = 3'h4;
            n.state = ITX_HEADER;
          end
        end else if (s.in_pay && !imm &&
                     (cmd == `ITX_CMD_MORE || cmd == `ITX_CMD_LAST)) begin
          n.baddr = s.ram[1];
          n.cnt = s.ram[0][15:0];
          n.state = ITX_PAYLOAD;
        end else begin
          n.evt = `ITX_EVT_UNKNOWN;
          n.abn = 1'b1;
          n.state = ITX_INTR;
        end
      end
      ITX_STORE: begin
        if (!s.dma.req) begin
          n.dma = '{1'b1, 1'b1, s.ram[1], {16'h0000, s.ram[0][15:0]}};
        end else if (dma_i.ack) begin
          n.dma.req = 1'b0;
          if (dma_i.err) begin
            n.evt = `ITX_EVT_DATA_WRITE;
            n.abn = 1'b1;
            n.state = ITX_INTR;
          end else begin
            n.da = 32'(s.da + 32'h10);
            n.idx = 3'h0;
            n.state = ITX_FETCH;
          end
        end
      end
      ITX_HEADER: begin
        if (s.cnt == 16'h0) begin
          if (s.ram[0][15:0] != 16'h0) begin
            // Serial layout header for the link
            n.hdr = '{s.ram[4][18:16], s.ram[5][31:16], s.ram[4][15:14],
                      s.ram[4][13:8], s.ram[4][7:4], s.ram[4][3:0]};
            n.hdr_v = 1'b1;
          end
          if (cmd == `ITX_CMD_LAST) begin
            n.state = ITX_WAIT_TX;
          end else begin
            n.in_pay = 1'b1;
            n.da = 32'(s.da + 32'h20);
            n.idx = 3'h0;
            n.state = ITX_FETCH;
          end
        end else if (q_free) begin
          n.q = '{1'b1, (cmd == `ITX_CMD_LAST) && (s.cnt <= 16'h4), s.ram[s.idx]};
          n.idx = 3'(s.idx + 3'h1);
          n.cnt = dec4(s.cnt);
        end
      end
      ITX_PAYLOAD: begin
        if (s.cnt == 16'h0 && !s.dma.req) begin
          if (cmd == `ITX_CMD_LAST) begin
            n.state = ITX_WAIT_TX;
          end else begin
            n.da = 32'(s.da + 32'h10);
            n.idx = 3'h0;
            n.state = ITX_FETCH;
          end
        end else if (!s.dma.req && !s.q.valid) begin
          n.dma = '{1'b1, 1'b0, s.baddr, 32'h0};
        end else if (s.dma.req && dma_i.ack) begin
          n.dma.req = 1'b0;
          if (dma_i.err) begin
            n.evt = `ITX_EVT_DATA_READ;
            n.abn = 1'b1;
            n.state = ITX_INTR;
          end else begin
            n.q = '{1'b1, (cmd == `ITX_CMD_LAST) && (s.cnt <= 16'h4), dma_i.rdata};
            n.baddr = 32'(s.baddr + 32'h4);
            n.cnt = dec4(s.cnt);
          end
        end
      end
      ITX_WAIT_TX: begin
        if (link_done) begin
          n.evt = `ITX_EVT_COMPLETE;
          n.state = ITX_INTR;
        end
      end
      ITX_SKIP: begin
        n.flush = 1'b1;
        n.q.valid = 1'b0;
        n.in_pay = 1'b0;
        n.skips = 8'(s.skips + 8'h1);
        if (s.skips >= s.lim) begin
          n.evt = `ITX_EVT_UNKNOWN;
          n.abn = 1'b1;
          n.state = ITX_INTR;
        end else if (s.skip[3:0] == 4'h0) begin
          n.state = ITX_IDLE;
        end else begin
          n.pp = {s.skip[31:4], 4'h0};
          n.da = {s.skip[31:4], 4'h0};
          n.newprog = 1'b1;
          n.idx = 3'h0;
          n.state = ITX_FETCH;
        end
      end
      ITX_INTR: begin
        // Event field already holds the code
        if (s.ram[0][27]) begin
          n.state = ITX_STATUS;
        end else begin
          n = finish(n);
          // Skip path flushed last cycle; one pulse is enough
          if (s.flush) begin
            n.flush = 1'b0;
          end
        end
      end
      ITX_STATUS: begin
        if (!s.dma.req) begin
          n.dma = '{1'b1, 1'b1, 32'(s.da + 32'hc), {11'h0, s.evt, cycle_timer}};
        end else if (dma_i.ack) begin
          n.dma.req = 1'b0;
          if (dma_i.err) begin
            n.evt = `ITX_EVT_DATA_WRITE;
            n.abn = 1'b1;
          end
          n = finish(n);
        end
      end
      default: begin
        n.state = ITX_IDLE;
      end
    endcase

    // Underrun while a packet is out ends it on the skip path
    if (link_underrun && (s.state == ITX_HEADER || s.state == ITX_PAYLOAD ||
        s.state == ITX_WAIT_TX || (s.state == ITX_FETCH && s.in_pay))) begin
      n.dma.req = 1'b0;
      n.evt = `ITX_EVT_UNDERRUN;
      n.state = ITX_SKIP;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.state <= ITX_IDLE;
      s.lim <= `ITX_LIM_RST;
    end else begin
      s <= n;
    end
  end

  assign wb_dat_o = s.wb_dat;
  assign wb_ack_o = s.wb_ack;
  assign dma_o = s.dma;
  assign tq_o = s.q;
  assign tq_flush = s.flush;
  assign link_hdr = s.hdr;
  assign link_hdr_valid = s.hdr_v;
  assign ctx_active = (s.state != ITX_IDLE);
endmodule : itx_sequencer

// >>> itx_sequencer_asserts.sv
// Port checker for the transmit sequencer.
// Assumes one clock domain; bound to the sequencer below.
`timescale 1ns/10ps
`include "itx_map.svh"
module itx_sequencer_asserts import itx_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire itx_dma_req_t dma_o,
  input wire itx_dma_rsp_t dma_i,
  input wire itx_queue_t tq_o,
  input wire logic tq_ready,
  input wire logic tq_flush,
  input wire itx_hdr_t link_hdr,
  input wire logic link_hdr_valid,
  input wire logic link_underrun,
  input wire logic ctx_active
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_wb_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_once)
    else $error("bus ack not one pulse");
  a_dma_req_hold: assert property (dma_o.req && !dma_i.ack |=> dma_o.req && $stable(dma_o.addr))
    else $error("dma request dropped early");
  a_dma_req_drop: assert property (dma_o.req && dma_i.ack |=> !dma_o.req)
    else $error("dma request held after ack");
  a_queue_word_hold: assert property (tq_o.valid && !tq_ready |=> tq_flush || (tq_o.valid && $stable(tq_o.data)))
    else $error("queue word changed before taken");
  a_hdr_tcode_iso: assert property (link_hdr_valid |-> link_hdr.tcode == `ITX_TCODE_ISO)
    else $error("header sent with wrong tcode");
  a_hdr_speed_legal: assert property (link_hdr_valid |-> link_hdr.spd <= `ITX_SPD_400)
    else $error("header speed code illegal");
  a_flush_one_pulse: assert property (tq_flush |=> !tq_flush)
    else $error("flush longer than a pulse");
  a_underrun_flush: assert property (link_underrun && ctx_active |-> ##[0:8] tq_flush)
    else $error("underrun not followed by flush");
endmodule : itx_sequencer_asserts

bind itx_sequencer itx_sequencer_asserts u_chk (.*);

// >>> itx_host_model.sv
// Host memory and link transmitter beside the sequencer.
// Assumes the bench preloads mem and picks error address.
`timescale 1ns/10ps
module itx_host_model import itx_pkg::*; #(
  parameter int LAT = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire itx_dma_req_t dma_o,
  output itx_dma_rsp_t dma_i,
  input wire itx_queue_t tq_o,
  output logic tq_ready,
  output logic link_done,
  output logic link_underrun,
  input wire logic [31:0] err_addr,
  input wire logic make_underrun,
  input wire logic err_write
);
  logic [31:0] mem [0:255];
  int wait_n;
  logic last_taken;
  assign last_taken = tq_o.valid && tq_ready && tq_o.last;
  // ----
  // Memory answers and link drain
  // ----
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_i <= '0;
      wait_n <= 0;
      tq_ready <= 1'b0;
      link_done <= 1'b0;
      link_underrun <= 1'b0;
    end else begin
      dma_i.ack <= 1'b0;
      dma_i.err <= 1'b0;
      // Idle data flips so stale reads never match
      dma_i.rdata <= ~dma_i.rdata;
      wait_n <= 0;
      if (dma_o.req && !dma_i.ack) begin
        wait_n <= wait_n + 1;
        if (wait_n == LAT) begin
          wait_n <= 0;
          dma_i.ack <= 1'b1;
          dma_i.err <= (dma_o.addr == err_addr) && (dma_o.we || !err_write);
          dma_i.rdata <= mem[dma_o.addr[9:2]];
          if (dma_o.we && dma_o.addr != err_addr) mem[dma_o.addr[9:2]] <= dma_o.wdata;
        end
      end
      // Half-rate drain keeps the queue stalling
      tq_ready <= ~tq_ready;
      link_done <= last_taken && !make_underrun;
      link_underrun <= last_taken && make_underrun;
    end
  end
endmodule : itx_host_model

// >>> itx_sequencer_tb.sv
// Self-checking bench for the transmit sequencer.
// Assumes the host model holds the descriptor programs.
`timescale 1ns/10ps
`include "itx_map.svh"
module itx_sequencer_tb import itx_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, err_addr = 32'hffff_ffff;
  logic wb_ack_o, tq_ready, tq_flush, link_hdr_valid, link_done, link_underrun, ctx_active;
  logic bus_reset = 1'b0, cycle_lost = 1'b0, make_underrun = 1'b0, err_write = 1'b0;
  logic [15:0] cycle_timer = 16'h5a5a;
  itx_dma_req_t dma_o;
  itx_dma_rsp_t dma_i;
  itx_queue_t tq_o;
  itx_hdr_t link_hdr;
  logic [31:0] qw [$];
  logic [31:0] hq [$];
  int num_errors = 0, n_checks = 0, n_flush = 0, n_last = 0;
  itx_sequencer dut (.*);
  itx_host_model m (.*);
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (tq_o.valid && tq_ready) qw.push_back(tq_o.data);
    if (link_hdr_valid) hq.push_back({13'h0, link_hdr.spd, link_hdr.tag, link_hdr.chan, link_hdr.tcode, link_hdr.sy});
    if (tq_flush) n_flush++;
    if (tq_o.valid && tq_ready && tq_o.last) n_last++;
  end
  // ----
  // Shared tasks
  // ----
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 50);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
    if (i >= 50) begin
      chk(32'h0, 32'h1);
      end_of_test();
    end
  endtask : wb
  task automatic evt(input logic [4:0] e);
    logic [31:0] r;
    wb(1'b0, `ITX_REG_CTRL, 32'h0, r);
    chk({27'h0, r[12:8]}, {27'h0, e});
  endtask : evt
  task automatic run(input logic [31:0] p);
    logic [31:0] r;
    int i;
    wb(1'b1, `ITX_REG_PTR, p, r);
    wb(1'b1, `ITX_REG_CTRL, 32'h1, r);
    i = 0;
    while (ctx_active !== 1'b1 && i < 20) begin
      @(posedge ref_clk);
      i++;
    end
    while (ctx_active !== 1'b0 && i < 5000) begin
      @(posedge ref_clk);
      i++;
      if (tq_flush === 1'b1) make_underrun <= 1'b0;
    end
    if (i >= 5000) begin
      chk(32'h0, 32'h1);
      end_of_test();
    end
  endtask : run
  // ----
  // Scenarios
  // ----
  task automatic t_chain();
    logic [31:0] r;
    run(32'h100);
    chk(m.mem[8'hc0], 32'h0000_1234);
    chk(32'(qw.size()), 32'd6);
    chk(qw[1], 32'h0008_0000);
    chk(qw[5], 32'hcafe_0002);
    chk(32'(n_last), 32'd2);
    chk(32'(hq.size()), 32'd2);
    chk(hq[0], 32'h0000_85a3);
    chk(hq[1], 32'h0002_85a3);
    chk({16'h0, link_hdr.len}, 32'h8);
    evt(`ITX_EVT_COMPLETE);
    chk(m.mem[8'h47], 32'h0011_5a5a);
    chk(m.mem[8'h8f], 32'h0011_5a5a);
    wb(1'b0, `ITX_REG_EVT, 32'h0, r);
    chk(r & 32'h1, 32'h1);
  endtask : t_chain
  task automatic t_errors();
    logic [31:0] r;
    logic [31:0] ea [4] = '{32'h100, 32'h300, 32'h11c, 32'h380};
    logic [31:0] ep [4] = '{32'h100, 32'h100, 32'h110, 32'h220};
    logic [4:0] ev [4] = '{`ITX_EVT_DESC_READ, `ITX_EVT_DATA_WRITE, `ITX_EVT_DATA_WRITE, `ITX_EVT_DATA_READ};
    int f0;
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, `ITX_REG_EVT, 32'h3, r);
      f0 = n_flush;
      err_addr <= ea[k];
      err_write <= (k == 2);
      run(32'h100);
      err_addr <= 32'hffff_ffff;
      err_write <= 1'b0;
      evt(ev[k]);
      wb(1'b0, `ITX_REG_PTR, 32'h0, r);
      chk(r, ep[k]);
      chk(32'(n_flush > f0), 32'h1);
      wb(1'b0, `ITX_REG_EVT, 32'h0, r);
      chk(r & 32'h2, (k == 2) ? 32'h2 : 32'h0);
    end
  endtask : t_errors
  task automatic t_tcode_skip();
    int f0;
    f0 = hq.size();
    run(32'h140);
    evt(`ITX_EVT_TCODE);
    chk(32'(hq.size()), 32'(f0));
    m.mem[8'h82] = 32'h0000_0100;
    make_underrun <= 1'b1;
    run(32'h200);
    evt(`ITX_EVT_UNDERRUN);
    m.mem[8'h82] = 32'h0000_0101;
    f0 = n_flush;
    m.mem[8'hc0] = 32'h0;
    m.mem[8'h84] = 32'h0001_85a3;
    make_underrun <= 1'b1;
    run(32'h200);
    chk(32'(n_flush > f0), 32'h1);
    chk(m.mem[8'hc0], 32'h0000_1234);
    chk(hq[$], 32'h0001_85a3);
  endtask : t_tcode_skip
  task automatic t_loss();
    logic [31:0] r;
    wb(1'b0, `ITX_REG_LIM, 32'h0, r);
    chk(r, 32'h8);
    wb(1'b0, 8'h20, 32'h0, r);
    chk(r, 32'h0);
    wb(1'b1, `ITX_REG_LIM, 32'h2, r);
    for (int k = 0; k < 2; k++) begin
      bus_reset <= (k == 0);
      cycle_lost <= (k == 1);
      run(32'h100);
      evt(`ITX_EVT_UNKNOWN);
    end
    bus_reset <= 1'b0;
    cycle_lost <= 1'b0;
  endtask : t_loss
  initial begin
    for (int k = 0; k < 256; k++) m.mem[k] = 32'h0;
    m.mem[8'h40] = 32'h8200_1234;
    m.mem[8'h41] = 32'h0000_0300;
    m.mem[8'h42] = 32'h0000_0101;
    m.mem[8'h44] = 32'h1a30_0008;
    m.mem[8'h46] = 32'h0000_0201;
    m.mem[8'h48] = 32'h0000_85a3;
    m.mem[8'h49] = 32'h0008_0000;
    m.mem[8'h50] = 32'h1200_0008;
    m.mem[8'h54] = 32'h0000_8513;
    m.mem[8'h55] = 32'h0008_0000;
    m.mem[8'h80] = 32'h0200_0008;
    m.mem[8'h82] = 32'h0000_0101;
    m.mem[8'h84] = 32'h0002_85a3;
    m.mem[8'h85] = 32'h0008_0000;
    m.mem[8'h88] = 32'h0000_0004;
    m.mem[8'h89] = 32'h0000_0380;
    m.mem[8'h8c] = 32'h1810_0004;
    m.mem[8'h8d] = 32'h0000_0384;
    m.mem[8'he0] = 32'hcafe_0001;
    m.mem[8'he1] = 32'hcafe_0002;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_chain();
    t_errors();
    t_tcode_skip();
    t_loss();
    end_of_test();
  end
endmodule : itx_sequencer_tb
